// *** badec_adder.sv ***
// 8-bit adder with the flag computation for add and add-with-carry
// assumes operands are stable for the cycle; purely combinational
`timescale 1ns/1ps
`default_nettype none
module badec_adder (
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire logic cin,
  input wire logic [7:0] flags_in,
  output badec_pkg::badec_res_t res
);
  import badec_pkg::*;
  logic [4:0] low;
  logic [8:0] full;
  always_comb begin
    low = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    res.result = full[7:0];
    res.flags = flags_in;
    res.flags[FLAG_S] = full[7];
    res.flags[FLAG_Z] = (full[7:0] == 8'h00);
    res.flags[FLAG_H] = low[4];
    res.flags[FLAG_PV] = (a[7] == b[7]) && (full[7] != a[7]);
    res.flags[FLAG_N] = 1'b0;
    res.flags[FLAG_C] = full[8];
  end
endmodule
`default_nettype wire

// *** badec_mem_model.sv ***
// datapath memory side: answers a memory request after a chosen lag
// assumes mem_req stays up until the byte is handed over
`timescale 1ns/1ps
`default_nettype none
module badec_mem_model (
  input wire logic mclk,
  input wire logic rst,
  input wire logic mem_req,
  input wire logic [7:0] val,
  input wire logic [3:0] lag,
  output logic mem_valid,
  output logic [7:0] mem_data
);
  logic [3:0] cnt;
  always_ff @(posedge mclk) begin
    mem_valid <= 1'b0;
    // released data is inverted every cycle, so a stale byte is never held steady
    mem_data <= ~mem_data;
    if (rst) begin
      cnt <= 4'h0;
      mem_data <= 8'h00;
    end else if (mem_req && !mem_valid) begin
      if (cnt == lag) begin
        mem_valid <= 1'b1;
        mem_data <= val;
        cnt <= 4'h0;
      end else begin
        cnt <= cnt + 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// *** badec_pkg.sv ***
// package for the byte alu op decoder: encodings, field layouts, flag bits, timing figures
// assumes nothing of its surroundings
package badec_pkg;
  localparam logic [2:0] REG_B = 3'h0;
  localparam logic [2:0] REG_C = 3'h1;
  localparam logic [2:0] REG_D = 3'h2;
  localparam logic [2:0] REG_E = 3'h3;
  localparam logic [2:0] REG_H = 3'h4;
  localparam logic [2:0] REG_L = 3'h5;
  localparam logic [2:0] REG_MEM = 3'h6;
  localparam logic [2:0] REG_A = 3'h7;
  localparam logic [1:0] PAIR_BC = 2'h0;
  localparam logic [1:0] PAIR_DE = 2'h1;
  localparam logic [1:0] PAIR_PTR = 2'h2;
  localparam logic [1:0] PAIR_TOP = 2'h3;
  localparam int FLAG_S = 7;
  localparam int FLAG_Z = 6;
  localparam int FLAG_H = 4;
  localparam int FLAG_PV = 2;
  localparam int FLAG_N = 1;
  localparam int FLAG_C = 0;
  localparam logic [1:0] TOP_ARITH = 2'h2;
  localparam logic [1:0] TOP_IMM = 2'h3;
  localparam logic [2:0] OP_ADD = 3'h0;
  localparam logic [2:0] OP_ADC = 3'h1;
  localparam logic [2:0] LOW_IMM = 3'h6;
  localparam logic [7:0] PREFIX_X = 8'hdd;
  localparam logic [7:0] PREFIX_Y = 8'hfd;
  localparam logic [4:0] STATES_REG = 5'h04;
  localparam logic [4:0] STATES_MEM = 5'h06;
  localparam logic [4:0] STATES_IDX = 5'h0e;
  localparam logic [1:0] BYTES_ONE = 2'h1;
  localparam logic [1:0] BYTES_TWO = 2'h2;
  localparam logic [1:0] BYTES_THREE = 2'h3;
  localparam logic [7:0] RST_STEP = 8'h08;
  typedef enum logic [3:0] {
    SEL_B, SEL_C, SEL_D, SEL_E, SEL_H, SEL_L, SEL_A, SEL_NONE,
    SEL_MEM_PTR, SEL_MEM_IDX, SEL_IMM
  } badec_src_t;
  typedef enum logic [2:0] {
    PR_BC, PR_DE, PR_POINTER_PAIR, PR_INDEX_REG_FIRST, PR_INDEX_REG_SECOND,
    PR_STACK_POINTER, PR_ACCUM_AND_FLAGS
  } badec_pair_t;
  // per-flag update control: keep, take computed value, force 1, force 0
  typedef enum logic [1:0] {FL_KEEP, FL_CALC, FL_SET, FL_CLR} badec_flctl_t;
  typedef struct packed {
    logic valid;
    logic is_adc;
    badec_src_t src;
    logic mem_read;
    logic use_index_y;
    logic [7:0] disp;
    logic [7:0] imm;
    logic [1:0] bytes;
    logic [4:0] states;
  } badec_dec_t;
  typedef struct packed {
    logic [7:0] result;
    logic [7:0] flags;
  } badec_res_t;
endpackage

// *** badec_props.sv ***
// checker for the decoder: field decode, flag controls and result timing
// assumes it is bound to badec_top and sees one clock domain
`timescale 1ns/1ps
`default_nettype none
module badec_props
  import badec_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [2:0] reg_field,
  input wire logic [2:0] bit_field,
  input wire logic [2:0] cond_field,
  input wire logic [2:0] rst_field,
  input wire logic [7:0] flags_now,
  input wire logic mem_req,
  input wire logic mem_valid,
  input wire badec_pkg::badec_src_t reg_sel,
  input wire logic [7:0] bit_mask,
  input wire logic cond_true,
  input wire logic [7:0] rst_target,
  input wire logic accum_we,
  input wire logic [7:0] accum_wdata,
  input wire logic [7:0] flags_wdata,
  input wire badec_pkg::badec_flctl_t [7:0] flag_ctl
);
  logic [2:0] ci;
  // flag position tested by each pair of condition codes
  assign ci = cond_field[2] ? (cond_field[1] ? 3'h7 : 3'h2) : (cond_field[1] ? 3'h0 : 3'h6);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  chk_reg_none: assert property (reg_field == 3'h6 |-> reg_sel == SEL_NONE)
    else $error("field 110 selected a register");
  chk_bit_onehot: assert property ($onehot(bit_mask) && bit_mask[bit_field])
    else $error("bit mask does not match field");
  chk_rst_addr: assert property (rst_target == {2'h0, rst_field, 3'h0})
    else $error("restart target wrong");
  chk_cond_flag: assert property (cond_true == (flags_now[ci] == cond_field[0]))
    else $error("condition result wrong");
  chk_mem_exec: assert property (mem_req && mem_valid |-> ##2 accum_we)
    else $error("no write two cycles after memory byte");
  chk_we_pulse: assert property (accum_we |=> !accum_we)
    else $error("accumulator write longer than one cycle");
  chk_flag_ctl: assert property (accum_we |-> flag_ctl[FLAG_N] == FL_CLR && flag_ctl[FLAG_C] == FL_CALC && flag_ctl[FLAG_H] == FL_CALC && flag_ctl[5] == FL_KEEP)
    else $error("flag controls wrong");
  chk_zero_sign: assert property (accum_we |-> flags_wdata[FLAG_Z] == (accum_wdata == 8'h00) && flags_wdata[FLAG_S] == accum_wdata[7] && !flags_wdata[FLAG_N])
    else $error("sign, zero or subtract flag wrong");
endmodule
`default_nettype wire

// *** badec_top.sv ***
// byte alu op decoder: operand field decode plus the add / add-with-carry group
// assumes fetch presents one instruction byte per cycle with a strobe, and the
// datapath returns the memory operand byte with a strobe when asked
// Overview of operation
// - 3-bit register field: B,C,D,E,H,L,-,A; 110 selects no register.
// - pair field: BC, DE, pointer pair or index, stack pointer or accum/flags.
// - high/low half names access the upper/lower byte of the pair.
// - bit field selects bit 0..7 as its binary value.
// - condition field tests zero, carry, parity and sign, clear or set.
// - restart target is eight times the field value.
// - flags: S7 Z6 H4 PV2 N1 C0, each kept, computed, set or cleared.
// - add 10000rrr, adc 10001rrr; immediate 11000110/11001110 plus a data byte.
// - 4 states register, 6 memory or immediate, indexed 3 bytes 14 states.
// - index prefixes dd/fd, then opcode, then signed displacement.
// - adc adds incoming carry; overflow into PV; subtract flag cleared.
// - field 110 takes the byte at the pointer pair address as source.
`timescale 1ns/1ps
`default_nettype none
module badec_top (
  input wire logic mclk,
  input wire logic rst,
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  input wire logic [2:0] reg_field,
  input wire logic [1:0] pair_field,
  input wire logic pair_push_pop,
  input wire logic pair_indexed,
  input wire logic pair_index_y,
  input wire logic [2:0] bit_field,
  input wire logic [2:0] cond_field,
  input wire logic [2:0] rst_field,
  input wire logic [7:0] flags_now,
  input wire logic [7:0] accum_now,
  input wire logic [7:0] src_reg_data,
  input wire logic mem_valid,
  input wire logic [7:0] mem_data,
  output badec_pkg::badec_src_t reg_sel,
  output badec_pkg::badec_pair_t pair_sel,
  output logic [7:0] bit_mask,
  output logic cond_true,
  output logic [7:0] rst_target,
  output badec_pkg::badec_dec_t dec,
  output logic need_byte,
  output logic mem_req,
  output logic [15:0] mem_offset,
  output logic accum_we,
  output logic [7:0] accum_wdata,
  output badec_pkg::badec_flctl_t [7:0] flag_ctl,
  output logic [7:0] flags_wdata
);
  import badec_pkg::*;

  function automatic badec_src_t map_reg(input logic [2:0] f);
    case (f)
      REG_B: map_reg = SEL_B;
      REG_C: map_reg = SEL_C;
      REG_D: map_reg = SEL_D;
      REG_E: map_reg = SEL_E;
      REG_H: map_reg = SEL_H; // upper byte of the pointer pair
      REG_L: map_reg = SEL_L;
      REG_A: map_reg = SEL_A;
      default: map_reg = SEL_NONE;
    endcase
  endfunction

  typedef enum logic [2:0] {
    ST_OP = 3'b000,
    ST_PFX = 3'b001,
    ST_DISP = 3'b011,
    ST_IMM = 3'b010,
    ST_MEM = 3'b110,
    ST_EXEC = 3'b111
  } badec_state_t;

  badec_state_t state;
  badec_state_t next_state;
  logic prefix_y;
  logic [7:0] operand;
  logic [7:0] src_byte;
  badec_res_t sum;
  logic is_arith;
  logic is_imm;

  // operand field decoders, combinational for the datapath
  always_comb begin
    reg_sel = map_reg(reg_field);
    case (pair_field)
      PAIR_BC: pair_sel = PR_BC;
      PAIR_DE: pair_sel = PR_DE;
      PAIR_PTR: pair_sel = !pair_indexed ? PR_POINTER_PAIR :
                           pair_index_y ? PR_INDEX_REG_SECOND : PR_INDEX_REG_FIRST;
      default: pair_sel = pair_push_pop ? PR_ACCUM_AND_FLAGS : PR_STACK_POINTER;
    endcase
    bit_mask = 8'h01 << bit_field;
    case (cond_field[2:1])
      2'h0: cond_true = flags_now[FLAG_Z] == cond_field[0];
      2'h1: cond_true = flags_now[FLAG_C] == cond_field[0];
      2'h2: cond_true = flags_now[FLAG_PV] == cond_field[0];
      default: cond_true = flags_now[FLAG_S] == cond_field[0];
    endcase
    rst_target = {5'h00, rst_field} * RST_STEP;
  end
  // the half select of a pair is the datapath's: SEL_H/SEL_L and index
  // halves are byte lanes [15:8] and [7:0] of the selected pair

  assign is_arith = byte_data[7:6] == TOP_ARITH &&
                    (byte_data[5:3] == OP_ADD || byte_data[5:3] == OP_ADC);
  assign is_imm = byte_data[7:6] == TOP_IMM && byte_data[2:0] == LOW_IMM &&
                  (byte_data[5:3] == OP_ADD || byte_data[5:3] == OP_ADC);

  always_comb begin
    next_state = state;
    case (state)
      ST_OP: begin
        if (byte_valid) begin
          if (byte_data == PREFIX_X || byte_data == PREFIX_Y) begin
            next_state = ST_PFX;
          end else if (is_imm) begin
            next_state = ST_IMM;
          end else if (is_arith && byte_data[2:0] == REG_MEM) begin
            next_state = ST_MEM;
          end else if (is_arith) begin
            next_state = ST_EXEC;
          end
        end
      end
      ST_PFX: begin
        if (byte_valid) begin
          // only the memory form is legal behind a prefix; otherwise drop it
          next_state = (is_arith && byte_data[2:0] == REG_MEM) ? ST_DISP : ST_OP;
        end
      end
      ST_DISP: if (byte_valid) next_state = ST_MEM;
      ST_IMM: if (byte_valid) next_state = ST_EXEC;
      ST_MEM: if (mem_valid) next_state = ST_EXEC;
      ST_EXEC: next_state = ST_OP;
      default: next_state = ST_OP;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) state <= ST_OP;
    else state <= next_state;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      dec <= '0;
      prefix_y <= 1'b0;
    end else begin
      case (state)
        ST_OP: if (byte_valid) begin
          dec <= '0;
          prefix_y <= byte_data == PREFIX_Y;
          if (is_arith || is_imm) begin
            dec.is_adc <= byte_data[5:3] == OP_ADC;
            dec.bytes <= is_imm ? BYTES_TWO : BYTES_ONE;
            dec.states <= (is_imm || byte_data[2:0] == REG_MEM) ?
                          STATES_MEM : STATES_REG;
            dec.src <= is_imm ? SEL_IMM :
                       (byte_data[2:0] == REG_MEM) ? SEL_MEM_PTR : map_reg(byte_data[2:0]);
            dec.mem_read <= is_arith && byte_data[2:0] == REG_MEM;
          end
        end
        ST_PFX: if (byte_valid) begin
          dec.is_adc <= byte_data[5:3] == OP_ADC;
          dec.use_index_y <= prefix_y;
          dec.src <= SEL_MEM_IDX;
          dec.mem_read <= 1'b1;
          dec.bytes <= BYTES_THREE;
          dec.states <= STATES_IDX;
        end
        ST_DISP: if (byte_valid) dec.disp <= byte_data;
        ST_IMM: if (byte_valid) dec.imm <= byte_data;
        ST_EXEC: dec.valid <= 1'b1;
        default: dec.valid <= 1'b0;
      endcase
      if (state == ST_OP && byte_valid) dec.valid <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) operand <= 8'h00;
    else if (state == ST_MEM && mem_valid) operand <= mem_data;
    else if (state == ST_IMM && byte_valid) operand <= byte_data;
  end

  assign need_byte = state == ST_OP || state == ST_PFX || state == ST_DISP || state == ST_IMM;
  assign mem_req = state == ST_MEM;
  // sign-extended displacement for the indexed address, zero for the pointer pair
  assign mem_offset = dec.src == SEL_MEM_IDX ? {{8{dec.disp[7]}}, dec.disp} : 16'h0000;
  assign src_byte = (dec.src == SEL_MEM_PTR || dec.src == SEL_MEM_IDX ||
                     dec.src == SEL_IMM) ? operand : src_reg_data;

  badec_adder u_adder (
    .a(accum_now),
    .b(src_byte),
    .cin(dec.is_adc & flags_now[FLAG_C]),
    .flags_in(flags_now),
    .res(sum)
  );

  // result and flags registered so they come from flip-flops
  always_ff @(posedge mclk) begin
    if (rst) begin
      accum_we <= 1'b0;
      accum_wdata <= 8'h00;
      flags_wdata <= 8'h00;
    end else begin
      accum_we <= state == ST_EXEC;
      if (state == ST_EXEC) begin
        accum_wdata <= sum.result;
        flags_wdata <= sum.flags;
      end
    end
  end

  // add group: S Z H C computed, PV overflow, N forced clear, bits 5 and 3 kept
  always_comb begin
    for (int i = 0; i < 8; i++) flag_ctl[i] = FL_KEEP;
    if (accum_we) begin
      flag_ctl[FLAG_S] = FL_CALC;
      flag_ctl[FLAG_Z] = FL_CALC;
      flag_ctl[FLAG_H] = FL_CALC;
      flag_ctl[FLAG_PV] = FL_CALC;
      flag_ctl[FLAG_N] = FL_CLR;
      flag_ctl[FLAG_C] = FL_CALC;
    end
  end
endmodule
`default_nettype wire

// *** tb_byte_alu_op_decoder.sv ***
// self-checking bench: field decode sweep, then random add/adc traffic
// assumes badec_top, badec_mem_model and badec_props are compiled with it
`timescale 1ns/1ps
`default_nettype none
module tb_byte_alu_op_decoder;
  import badec_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic byte_valid = 1'b0, pair_push_pop = 1'b0, pair_indexed = 1'b0, pair_index_y = 1'b0;
  logic [7:0] byte_data = 8'h00, flags_now = 8'h00, accum_now = 8'h00, src_reg_data = 8'h00;
  logic [7:0] mem_val = 8'h00, mem_data, bit_mask, rst_target, accum_wdata, flags_wdata;
  logic [2:0] reg_field = 3'h0, bit_field = 3'h0, cond_field = 3'h0, rst_field = 3'h0;
  logic [1:0] pair_field = 2'h0;
  logic [3:0] lag = 4'h0;
  logic mem_valid, need_byte, mem_req, cond_true, accum_we;
  logic [15:0] mem_offset;
  badec_src_t reg_sel;
  badec_pair_t pair_sel;
  badec_dec_t dec;
  badec_flctl_t [7:0] flag_ctl;
  int n_fail = 0, compares = 0, cyc = 0;
  always #2.5 mclk = ~mclk;
  badec_top badec_top_i (.mclk, .rst, .byte_valid, .byte_data, .reg_field, .pair_field,
    .pair_push_pop, .pair_indexed, .pair_index_y, .bit_field, .cond_field, .rst_field,
    .flags_now, .accum_now, .src_reg_data, .mem_valid, .mem_data, .reg_sel, .pair_sel,
    .bit_mask, .cond_true, .rst_target, .dec, .need_byte, .mem_req, .mem_offset,
    .accum_we, .accum_wdata, .flag_ctl, .flags_wdata);
  badec_mem_model badec_mem_model_i (.mclk, .rst, .mem_req, .val(mem_val), .lag, .mem_valid,
    .mem_data);
  task automatic print_verdict();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // reference add: {flags, result}; bits 5 and 3 pass through
  function automatic logic [15:0] add_ref(int a, int b, int c, logic [7:0] f);
    int s;
    logic [7:0] r;
    s = a + b + c;
    r = s[7:0];
    return {r[7], r == 8'h00, f[5], (a % 16) + (b % 16) + c > 15, f[3],
      a[7] == b[7] && r[7] != a[7], 1'b0, s > 255, r};
  endfunction
  // kind: 0 register, 1 pointer pair, 2 immediate, 3 first index, 4 second index
  task automatic run_op(input int kind, input logic adc);
    logic [7:0] a, b, d, fl, q[$];
    logic [2:0] r;
    int i;
    a = $urandom;
    b = $urandom;
    d = $urandom;
    fl = $urandom;
    do r = $urandom; while (kind == 0 && r == 3'h6);
    if (kind != 0)
      r = 3'h6;
    // the accumulator as its own source reads what the adder sees as the other operand
    if (kind == 0 && r == 3'h7)
      b = a;
    accum_now <= a;
    flags_now <= fl;
    src_reg_data <= b;
    mem_val <= b;
    lag <= 4'($urandom % 4);
    // an ignored opcode ahead must not disturb the next one
    if ($urandom % 4 == 0)
      q.push_back(8'ha0);
    // a prefix ahead of a non-memory add is dropped and must leave no trace
    if ($urandom % 4 == 0) begin
      q.push_back(PREFIX_Y);
      q.push_back(8'h80);
    end
    if (kind > 2)
      q.push_back(kind == 3 ? PREFIX_X : PREFIX_Y);
    q.push_back({kind == 2 ? 2'h3 : 2'h2, 2'h0, adc, r});
    if (kind > 1)
      q.push_back(kind == 2 ? b : d);
    foreach (q[k]) begin
      byte_valid <= 1'b1;
      byte_data <= q[k];
      i = 0;
      do begin
        @(posedge mclk);
        i++;
      end while (need_byte !== 1'b1 && i < 20);
    end
    byte_valid <= 1'b0;
    i = 0;
    while (accum_we !== 1'b1 && i < 30) begin
      @(posedge mclk);
      i++;
      if (mem_req === 1'b1)
        check(mem_offset, kind > 2 ? {{8{d[7]}}, d} : 16'h0000);
    end
    check(16'(accum_we), 16'h0001);
    check(16'(flag_ctl), 16'({FL_CALC, FL_CALC, FL_KEEP, FL_CALC, FL_KEEP, FL_CALC, FL_CLR,
      FL_CALC}));
    check({dec.disp, dec.imm}, kind == 2 ? {8'h00, b} : kind > 2 ? {d, 8'h00} : 16'h0000);
    check({flags_wdata, accum_wdata}, add_ref(a, b, adc & fl[0], fl));
    check(16'({dec.valid, dec.is_adc, dec.mem_read, dec.use_index_y, dec.bytes, dec.states}),
      16'({1'b1, adc, kind == 1 || kind > 2, kind == 4, kind > 2 ? 2'h3 : kind == 2 ? 2'h2 :
      2'h1, kind > 2 ? 5'h0e : kind == 0 ? 5'h04 : 5'h06}));
    check(16'(dec.src), 16'(kind == 0 ? (r == 3'h7 ? SEL_A : badec_src_t'(r)) : kind == 1 ?
      SEL_MEM_PTR : kind == 2 ? SEL_IMM : SEL_MEM_IDX));
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      n_fail++;
      print_verdict();
    end
  end
  initial begin
    badec_pair_t pe;
    void'($urandom(32'hbeaf1335));
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    for (int i = 0; i < 32; i++) begin
      {pair_field, pair_push_pop, pair_indexed, pair_index_y} <= i[4:0];
      {reg_field, bit_field, cond_field, rst_field} <= {4{i[2:0]}};
      flags_now <= $urandom;
      @(negedge mclk);
      pe = i[4:3] == 2'h0 ? PR_BC : i[4:3] == 2'h1 ? PR_DE : i[4:3] == 2'h2 ? (i[1] ? (i[0] ?
        PR_INDEX_REG_SECOND : PR_INDEX_REG_FIRST) : PR_POINTER_PAIR) : (i[2] ?
        PR_ACCUM_AND_FLAGS : PR_STACK_POINTER);
      check(16'(pair_sel), 16'(pe));
      check(16'(reg_sel), 16'(i[2:0] == 3'h7 ? SEL_A : i[2:0] == 3'h6 ? SEL_NONE :
        badec_src_t'(i[2:0])));
      check(16'(bit_mask), 16'(8'h01 << i[2:0]));
      check(16'(cond_true), 16'(flags_now[i[2] ? (i[1] ? FLAG_S : FLAG_PV) :
        (i[1] ? FLAG_C : FLAG_Z)] == i[0]));
      check(16'(rst_target), 16'(i[2:0]) * 16'h0008);
      @(posedge mclk);
    end
    for (int k = 0; k < 200; k++)
      run_op($urandom % 5, 1'($urandom));
    print_verdict();
  end
endmodule
bind badec_top badec_props badec_props_i (.mclk, .rst, .reg_field, .bit_field, .cond_field,
  .rst_field, .flags_now, .mem_req, .mem_valid, .reg_sel, .bit_mask, .cond_true, .rst_target,
  .accum_we, .accum_wdata, .flags_wdata, .flag_ctl);
`default_nettype wire
